// ### include/uis_pkg.sv
// constants and types shared by the serial channel modules
package uis_pkg;
  // ==========================================================
  // register offsets
  localparam logic [15:0] ADDR_STATUS = 16'h4100;
  localparam logic [15:0] ADDR_TXHOLD = 16'h4101;
  localparam logic [15:0] ADDR_RXHOLD = 16'h4102;
  localparam logic [15:0] ADDR_FORMAT = 16'h4103;
  localparam logic [15:0] ADDR_CTRL   = 16'h4104;
  localparam logic [15:0] ADDR_IRSEL  = 16'h4105;
  localparam logic [15:0] ADDR_BAUD   = 16'h4106;
  localparam logic [15:0] ADDR_FINE   = 16'h4107;
  localparam logic [15:0] ADDR_CLKSRC = 16'h506C;
  // ==========================================================
  // field positions
  localparam int ST_TXDONE = 7;
  localparam int ST_FER    = 6;
  localparam int ST_PER    = 5;
  localparam int ST_OER    = 4;
  localparam int FM_LEN8   = 4;
  localparam int FM_PAR    = 3;
  localparam int FM_ODD    = 2;
  localparam int FM_STOP2  = 1;
  localparam int CT_TXDIE  = 7;
  localparam int CT_RXEIE  = 6;
  localparam int CT_RXFIE  = 5;
  localparam int CT_TXEIE  = 4;
  localparam int CT_DEPTH  = 1;
  localparam int CT_ON     = 0;
  localparam int IR_MODE   = 0;
  localparam int CK_DIV    = 4;
  localparam int CK_SRC    = 2;
  localparam int CK_ON     = 0;
  // ==========================================================
  // writable bit masks and reset values
  localparam logic [7:0] MASK_FORMAT = 8'h1E;
  localparam logic [7:0] MASK_CTRL   = 8'hF3;
  localparam logic [7:0] MASK_IRSEL  = 8'h01;
  localparam logic [7:0] MASK_FINE   = 8'h0F;
  localparam logic [7:0] MASK_CLKSRC = 8'h3D;
  localparam logic [7:0] RST_REG     = 8'h00;
  // ==========================================================
  // timing: 16 ticks per bit
  localparam logic [3:0] TICK_LAST  = 4'hF;
  localparam logic [3:0] TICK_MID   = 4'h7;
  localparam logic [3:0] IR_PULSE   = 4'h2;
  localparam logic [3:0] RX_BITS_MAX = 4'h9;
  localparam logic [3:0] TX_LEN_BASE = 4'h9;
  localparam logic [1:0] SRC_INT    = 2'h0;
  localparam logic [1:0] SRC_LOW    = 2'h1;
  localparam logic [1:0] SRC_HIGH   = 2'h2;
  // ==========================================================
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} uis_tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11
  } uis_rx_state_t;
endpackage

// ### logic/uis_baud.sv
// count clock selection, prescaler and fine-tuned baud divisor
module uis_baud (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [1:0] src_sel_i,
  input  wire logic [1:0] prescale_sel_i,
  input  wire logic       count_clock_on_i,
  input  wire logic [7:0] divisor_i,
  input  wire logic [3:0] fine_i,
  input  wire logic       internal_osc_i,
  input  wire logic       low_osc_i,
  input  wire logic       high_osc_i,
  input  wire logic       ext_clk_i,
  output logic            tick_o
);
  import uis_pkg::*;
  typedef struct packed {
    logic [2:0] pre;
    logic [7:0] cnt;
    logic [3:0] ufl;
    logic       delay;
    logic       tick;
  } uis_baud_st_t;
  uis_baud_st_t r, n;
  logic       src;
  logic       scaled;
  logic [2:0] pre_last;
  logic       cclk;
  always_comb begin
    n = r;
    n.tick = 1'b0;
    case (src_sel_i)
      SRC_INT:  src = internal_osc_i;
      SRC_LOW:  src = low_osc_i;
      SRC_HIGH: src = high_osc_i;
      default:  src = ext_clk_i;
    endcase
    scaled = (src_sel_i == SRC_INT) || (src_sel_i == SRC_HIGH);
    case (prescale_sel_i)
      2'h0:    pre_last = 3'd1;
      2'h3:    pre_last = 3'd7;
      default: pre_last = 3'd3;
    endcase
    cclk = 1'b0;
    if (src) begin
      if (!scaled) begin
        cclk = 1'b1;
      end else if (r.pre == pre_last) begin
        n.pre = 3'd0;
        cclk = 1'b1;
      end else begin
        n.pre = r.pre + 3'd1;
      end
    end
    if (cclk) begin
      if (r.delay) begin
        n.delay = 1'b0;
      end else if (r.cnt == 8'h00) begin
        n.tick = 1'b1;
        n.cnt = divisor_i;
        n.ufl = r.ufl + 4'h1;
        n.delay = (r.ufl < fine_i);
      end else begin
        n.cnt = r.cnt - 8'h01;
      end
    end
    if (!count_clock_on_i) begin
      n = '0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign tick_o = r.tick;
endmodule

// ### logic/uis_rx.sv
// receive framer with optional infrared pulse decoding
module uis_rx (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       tick_i,
  input  wire logic       enable_i,
  input  wire logic       line_i,
  input  wire logic       infrared_i,
  input  wire logic       len8_i,
  input  wire logic       par_on_i,
  input  wire logic       par_odd_i,
  output logic            done_o,
  output logic [7:0]      data_o,
  output logic            frame_err_o,
  output logic            par_err_o
);
  import uis_pkg::*;
  typedef struct packed {
    uis_rx_state_t st;
    logic [3:0]    tcnt;
    logic [3:0]    bidx;
    logic [8:0]    sh;
    logic [3:0]    hold;
    logic          done;
    logic [7:0]    data;
    logic          fer;
    logic          parity_err_flag;
  } uis_rx_st_t;
  uis_rx_st_t r, n;
  logic       bitv;
  logic [3:0] nbits;
  logic [8:0] al;
  logic [7:0] d;
  logic       pb;
  always_comb begin
    n = r;
    n.done = 1'b0;
    // a short infrared pulse marks a zero for the rest of the bit
    if (line_i) begin
      n.hold = TICK_LAST;
    end else if (tick_i && r.hold != 4'h0) begin
      n.hold = r.hold - 4'h1;
    end
    bitv = infrared_i ? (r.hold == 4'h0 && !line_i) : line_i;
    nbits = 4'd7 + {3'b0, len8_i} + {3'b0, par_on_i};
    al = r.sh >> (RX_BITS_MAX - nbits);
    d = len8_i ? al[7:0] : {1'b0, al[6:0]};
    pb = len8_i ? al[8] : al[7];
    if (tick_i) begin
      case (r.st)
        RX_IDLE: begin
          if (!bitv) begin
            n.st = RX_START;
            n.tcnt = 4'h0;
          end
        end
        RX_START: begin
          n.tcnt = r.tcnt + 4'h1;
          if (r.tcnt == TICK_MID) begin
            n.st = bitv ? RX_IDLE : RX_DATA;
            n.tcnt = 4'h0;
            n.bidx = 4'h0;
          end
        end
        RX_DATA: begin
          n.tcnt = r.tcnt + 4'h1;
          if (r.tcnt == TICK_LAST) begin
            if (r.bidx < nbits) begin
              n.sh = {bitv, r.sh[8:1]};
              n.bidx = r.bidx + 4'h1;
            end else begin
              n.st = RX_IDLE;
              n.done = 1'b1;
              n.data = d;
              n.fer = !bitv;
              n.parity_err_flag = par_on_i && (pb != (^d ^ par_odd_i));
            end
          end
        end
        default: n.st = RX_IDLE;
      endcase
    end
    if (!enable_i) begin
      n.st = RX_IDLE;
      n.done = 1'b0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign done_o = r.done;
  assign data_o = r.data;
  assign frame_err_o = r.fer;
  assign par_err_o = r.parity_err_flag;
endmodule

// ### logic/uis_uart.sv
// serial channel top: registers, two-byte receive buffer, transmitter
// What this block does
// - end of transmission flag at status bit 7, cleared by writing one
// - framing, parity, overrun errors at status bits 6, 5, 4
// - two received bytes held; bit 3 shows second byte waiting
// - status bit 2 shows transmit shifter busy
// - status bit 1 set while receive buffer holds data
// - status bit 0 shows transmit buffer empty, one after reset
// - receive register reads oldest character first
// - seven-bit characters use bit 6 as top bit
// - length bit selects eight or seven data bits
// - parity enable bit 3, odd when bit 2 set, even otherwise
// - stop select gives two or one stop bits
// - separate interrupt enables at control bits 7 to 4
// - receive full condition after two bytes or one byte
// - channel works only while control bit 0 set
// - expansion bit 0 selects infrared line encoding
// - 8-bit baud divisor, reset zero, sets bit timing
// - fine adjust inserts up to 15 delays per 16 underflows
// - 2-bit clock source select among four sources
// - prescaler divides internal or high-speed source
// - count clock runs only while clock enable bit set
module uis_uart (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        internal_osc_i,
  input  wire logic        low_osc_i,
  input  wire logic        high_osc_i,
  input  wire logic        ext_clk_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             irq_o
);
  import uis_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]    fmt;
    logic [7:0]    ctl;
    logic [7:0]    irs;
    logic [7:0]    baud;
    logic [7:0]    fine;
    logic [7:0]    clk;
    logic [7:0]    txbuf;
    logic          txfull;
    uis_tx_state_t tx_st;
    logic [3:0]    ttick;
    logic [3:0]    tbit;
    logic [3:0]    tlen;
    logic [11:0]   tsh;
    logic          txd;
    logic          done;
    logic          fer;
    logic          parity_err_flag;
    logic          overrun_err_flag;
    logic [7:0]    rxb0;
    logic [7:0]    rxb1;
    logic [1:0]    rxcnt;
    logic [7:0]    rdata;
    logic          irq;
  } uis_top_st_t;

  uis_top_st_t r;
  uis_top_st_t n;

  logic       tick;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_fer;
  logic       rx_per;

  logic       on;
  logic       len8;
  logic       par_on;
  logic       par_odd;
  logic       stop2;
  logic       ir;
  logic [7:0] status;
  logic       rx_cond;
  logic [7:0] td;
  logic       tp;
  logic [8:0] ext;
  logic [1:0] cnt_after;
  logic       wsel_st;

  // ==========================================================
  // count clock and receiver
  uis_baud u_baud (
    .ref_clk_i        (ref_clk_i),
    .sys_rst_i        (sys_rst_i),
    .src_sel_i        (r.clk[CK_SRC+1:CK_SRC]),
    .prescale_sel_i   (r.clk[CK_DIV+1:CK_DIV]),
    .count_clock_on_i (r.clk[CK_ON]),
    .divisor_i        (r.baud),
    .fine_i           (r.fine[3:0]),
    .internal_osc_i   (internal_osc_i),
    .low_osc_i        (low_osc_i),
    .high_osc_i       (high_osc_i),
    .ext_clk_i        (ext_clk_i),
    .tick_o           (tick)
  );

  uis_rx u_rx (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .tick_i      (tick),
    .enable_i    (on),
    .line_i      (rxd_i),
    .infrared_i  (ir),
    .len8_i      (len8),
    .par_on_i    (par_on),
    .par_odd_i   (par_odd),
    .done_o      (rx_done),
    .data_o      (rx_data),
    .frame_err_o (rx_fer),
    .par_err_o   (rx_per)
  );

  // ==========================================================
  // next state
  always_comb begin
    n = r;
    on      = r.ctl[CT_ON];
    len8    = r.fmt[FM_LEN8];
    par_on  = r.fmt[FM_PAR];
    par_odd = r.fmt[FM_ODD];
    stop2   = r.fmt[FM_STOP2];
    ir      = r.irs[IR_MODE];

    status = {r.done, r.fer, r.parity_err_flag, r.overrun_err_flag,
              r.rxcnt == 2'd2,
              r.tx_st != TX_IDLE,
              r.rxcnt != 2'd0,
              !r.txfull};

    // read data stand only in the cycle after the strobe
    n.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i == ADDR_STATUS) begin
        n.rdata = status;
      end else if (addr_i == ADDR_TXHOLD) begin
        n.rdata = r.txbuf;
      end else if (addr_i == ADDR_RXHOLD) begin
        n.rdata = r.rxb0;
      end else if (addr_i == ADDR_FORMAT) begin
        n.rdata = r.fmt;
      end else if (addr_i == ADDR_CTRL) begin
        n.rdata = r.ctl;
      end else if (addr_i == ADDR_IRSEL) begin
        n.rdata = r.irs;
      end else if (addr_i == ADDR_BAUD) begin
        n.rdata = r.baud;
      end else if (addr_i == ADDR_FINE) begin
        n.rdata = r.fine;
      end else if (addr_i == ADDR_CLKSRC) begin
        n.rdata = r.clk;
      end else begin
        n.rdata = 8'h00;
      end
    end

    // receive buffer pop: oldest first, younger one moves up
    if (rd_i && addr_i == ADDR_RXHOLD && r.rxcnt != 2'd0) begin
      n.rxb0 = r.rxb1;
      n.rxcnt = r.rxcnt - 2'd1;
    end

    // ==========================================================
    // configuration writes
    wsel_st = wr_i && addr_i == ADDR_STATUS;
    if (wsel_st) begin
      // flags clear by writing one; sets further down win
      if (wdata_i[ST_TXDONE]) begin
        n.done = 1'b0;
      end
      if (wdata_i[ST_FER]) begin
        n.fer = 1'b0;
      end
      if (wdata_i[ST_PER]) begin
        n.parity_err_flag = 1'b0;
      end
      if (wdata_i[ST_OER]) begin
        n.overrun_err_flag = 1'b0;
      end
    end
    if (wr_i) begin
      if (addr_i == ADDR_FORMAT) begin
        n.fmt = wdata_i & MASK_FORMAT;
      end else if (addr_i == ADDR_CTRL) begin
        n.ctl = wdata_i & MASK_CTRL;
      end else if (addr_i == ADDR_IRSEL) begin
        n.irs = wdata_i & MASK_IRSEL;
      end else if (addr_i == ADDR_BAUD) begin
        n.baud = wdata_i;
      end else if (addr_i == ADDR_FINE) begin
        n.fine = wdata_i & MASK_FINE;
      end else if (addr_i == ADDR_CLKSRC) begin
        n.clk = wdata_i & MASK_CLKSRC;
      end
    end

    // ==========================================================
    // receive buffer push, overrun drops the new byte
    cnt_after = n.rxcnt;
    if (rx_done) begin
      if (cnt_after == 2'd0) begin
        n.rxb0 = rx_data;
        n.rxcnt = 2'd1;
      end else if (cnt_after == 2'd1) begin
        n.rxb1 = rx_data;
        n.rxcnt = 2'd2;
      end else begin
        n.overrun_err_flag = 1'b1;
      end
      if (rx_fer) begin
        n.fer = 1'b1;
      end
      if (rx_per) begin
        n.parity_err_flag = 1'b1;
      end
    end

    // ==========================================================
    // transmitter
    td = len8 ? r.txbuf : {1'b0, r.txbuf[6:0]};
    tp = ^td ^ par_odd;
    if (par_on) begin
      ext = len8 ? {tp, td} : {1'b1, tp, td[6:0]};
    end else begin
      ext = len8 ? {1'b1, td} : {2'b11, td[6:0]};
    end

    case (r.tx_st)
      TX_IDLE: begin
        if (on && r.txfull) begin
          n.tx_st = TX_SHIFT;
          n.tsh = {2'b11, ext, 1'b0};
          n.tlen = TX_LEN_BASE + {3'b0, len8} + {3'b0, par_on}
                   + {3'b0, stop2};
          n.ttick = 4'h0;
          n.tbit = 4'h0;
          n.txfull = 1'b0;
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          n.ttick = r.ttick + 4'h1;
          if (r.ttick == TICK_LAST) begin
            n.tsh = {1'b1, r.tsh[11:1]};
            n.tbit = r.tbit + 4'h1;
            if (r.tbit == r.tlen - 4'h1) begin
              n.tx_st = TX_IDLE;
              // done only when nothing more waits to go out
              if (!r.txfull) begin
                n.done = 1'b1;
              end
            end
          end
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase

    // a write after the load refills the buffer for the next char
    if (wr_i && addr_i == ADDR_TXHOLD) begin
      n.txbuf = wdata_i;
      n.txfull = 1'b1;
    end

    if (!on) begin
      // disabling aborts a character in flight
      n.tx_st = TX_IDLE;
    end

    // ==========================================================
    // line drive: idle high plain, idle low infrared
    if (n.tx_st != TX_SHIFT) begin
      n.txd = !ir;
    end else if (ir) begin
      n.txd = !n.tsh[0] && n.ttick <= IR_PULSE;
    end else begin
      n.txd = n.tsh[0];
    end

    rx_cond = r.ctl[CT_DEPTH] ? (r.rxcnt == 2'd2) : (r.rxcnt != 2'd0);
    n.irq = (r.done && r.ctl[CT_TXDIE])
            || ((r.fer || r.parity_err_flag || r.overrun_err_flag) && r.ctl[CT_RXEIE])
            || (rx_cond && r.ctl[CT_RXFIE])
            || (!r.txfull && r.ctl[CT_TXEIE]);
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      r <= '0;
      r.fmt <= RST_REG;
      r.ctl <= RST_REG;
      r.irs <= RST_REG;
      r.baud <= RST_REG;
      r.fine <= RST_REG;
      r.clk <= RST_REG;
      r.txbuf <= RST_REG;
      r.tx_st <= TX_IDLE;
      r.txd <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign rdata_o = r.rdata;
  assign txd_o = r.txd;
  assign irq_o = r.irq;
endmodule

// ### testbench/uis_uart_props.sv
// port assertions for the serial channel top
module uis_uart_props (
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        txd_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import uis_pkg::*;
  // ==========
  // mode shadow kept from bus writes
  logic       ch_r;
  logic       ir_r;
  logic       txw_r;
  logic [3:0] en_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ch_r  <= 1'b0;
      ir_r  <= 1'b0;
      txw_r <= 1'b0;
      en_r  <= 4'h0;
    end else if (wr_i) begin
      if (addr_i == ADDR_CTRL) begin
        ch_r <= wdata_i[CT_ON];
        en_r <= wdata_i[7:4];
      end
      if (addr_i == ADDR_IRSEL) ir_r <= wdata_i[IR_MODE];
      if (addr_i == ADDR_TXHOLD) txw_r <= 1'b1;
    end
  end
  // ==========
  // properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_wr_rd(logic [15:0] a);
    wr_i && addr_i == a ##1 rd_i && addr_i == a;
  endsequence
  property p_back(logic [15:0] a, logic [7:0] m);
    s_wr_rd(a) |=> rdata_o == ($past(wdata_i, 2) & m);
  endproperty
  a_fmt_back: assert property (p_back(ADDR_FORMAT, MASK_FORMAT))
    else $error("format read back wrong");
  a_ctrl_back: assert property (p_back(ADDR_CTRL, MASK_CTRL))
    else $error("control read back wrong");
  a_baud_back: assert property (p_back(ADDR_BAUD, 8'hFF))
    else $error("divisor read back wrong");
  a_fine_back: assert property (p_back(ADDR_FINE, MASK_FINE))
    else $error("fine adjust read back wrong");
  a_clk_back: assert property (p_back(ADDR_CLKSRC, MASK_CLKSRC))
    else $error("clock control read back wrong");
  // a bit lasts at least 16 reference cycles, even at divisor zero
  a_bit_width: assert property ($fell(txd_o) && !ir_r && !$past(ir_r)
    |-> !txd_o [*8] ##1 !txd_o [*8]) else $error("low bit too short");
  a_off_idle: assert property (!ch_r && !$past(ch_r) && !ir_r && !$past(ir_r)
    |-> txd_o) else $error("line not idle high while off");
  a_ir_idle: assert property (ir_r && $past(ir_r) && !ch_r && !$past(ch_r)
    |-> !txd_o) else $error("infrared line not idle low");
  a_irq_quiet: assert property (en_r == 4'h0 && $past(en_r) == 4'h0
    |-> !irq_o) else $error("request with all enables off");
  a_irq_empty: assert property (!txw_r && en_r[0] && $past(en_r[0])
    |-> irq_o) else $error("no request for empty buffer");
endmodule

bind uis_uart uis_uart_props u_props (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .addr_i   (addr_i),
  .wdata_i  (wdata_i),
  .wr_i     (wr_i),
  .rd_i     (rd_i),
  .rdata_o  (rdata_o),
  .txd_o    (txd_o),
  .irq_o    (irq_o)
);

// ### testbench/uis_peer.sv
// remote serial end: frames characters onto the line and decodes replies
module uis_peer #(
  parameter int BIT_CYC = 32
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle line rests high
  initial line_o = 1'b1;
  // f holds length, parity on, odd, two stops; bp and bs spoil a frame
  task automatic send(input logic [7:0] d, input logic [3:0] f, input logic bp,
                      input logic bs);
    logic q[$];
    q.push_back(1'b0);
    for (int i = 0; i < (f[3] ? 8 : 7); i++) q.push_back(d[i]);
    if (f[2]) q.push_back((f[3] ? ^d : ^d[6:0]) ^ f[1] ^ bp);
    q.push_back(!bs);
    if (f[0]) q.push_back(1'b1);
    q.push_back(1'b1);
    foreach (q[i]) begin
      line_o <= q[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask
  // sampling mid-bit leaves room for a few cycles of tick alignment
  task automatic recv(input logic [3:0] f, output logic [7:0] d, output logic p);
    d = 8'h00;
    p = 1'b0;
    for (int w = 0; w < 4000 && line_i; w++) @(posedge clk_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < (f[3] ? 8 : 7); i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      d[i] = line_i;
    end
    if (f[2]) begin
      repeat (BIT_CYC) @(posedge clk_i);
      p = line_i;
    end
  endtask
endmodule

// ### testbench/uart_irda_serial_tb.sv
// self-checking bench for the serial channel
module uart_irda_serial_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uis_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [3:0]  osc = 4'h8;
  logic        rxd_i;
  logic [7:0]  rdata_o;
  logic        txd_o;
  logic        irq_o;
  logic [31:0] seed = 32'h00012F3C;
  int          errors = 0;
  int          compares = 0;
  localparam logic [15:0] ADR[9] = '{ADDR_STATUS, ADDR_TXHOLD, ADDR_RXHOLD, ADDR_FORMAT,
    ADDR_CTRL, ADDR_IRSEL, ADDR_BAUD, ADDR_FINE, ADDR_CLKSRC};
  localparam logic [7:0] MSK[9] = '{8'h00, 8'h00, 8'h00, MASK_FORMAT, MASK_CTRL,
    MASK_IRSEL, 8'hFF, MASK_FINE, MASK_CLKSRC};

  always #2.5 ref_clk_i = ~ref_clk_i;

  uis_uart u_dut (
    .ref_clk_i     (ref_clk_i),
    .sys_rst_i     (sys_rst_i),
    .addr_i        (addr_i),
    .wdata_i       (wdata_i),
    .wr_i          (wr_i),
    .rd_i          (rd_i),
    .rdata_o       (rdata_o),
    .internal_osc_i(osc[0]),
    .low_osc_i     (osc[1]),
    .high_osc_i    (osc[2]),
    .ext_clk_i     (osc[3]),
    .rxd_i         (rxd_i),
    .txd_o         (txd_o),
    .irq_o         (irq_o)
  );
  // divisor 1 on an every-cycle source gives 32 cycles a bit
  uis_peer #(.BIT_CYC(32)) u_peer (.clk_i(ref_clk_i), .line_i(txd_o), .line_o(rxd_i));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 q = rdata_o;
    @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic wait_st(input int b, input logic v);
    logic [7:0] q;
    q = {8{~v}};
    for (int i = 0; i < 3000 && q[b] !== v; i++) acc(1'b0, ADDR_STATUS, 8'h00, q);
    chk("status bit", {7'h00, v}, {7'h00, q[b]});
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========
  // watchdog: roughly six times the expected run
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    errors++;
    finish_test();
  end

  // ==========
  // main sequence
  initial begin
    logic [7:0] q, v, d, e;
    logic [3:0] f;
    logic       p;
    time        t0;
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, ADR[i], 8'h00, q);
      chk("reset value", (i == 0) ? 8'h01 : 8'h00, q);
    end
    wr(ADDR_CTRL, 8'h10);
    #1 chk("empty request", 8'h01, {7'h00, irq_o});
    for (int i = 3; i < 9; i++) begin
      v = rnd();
      addr_i  <= ADR[i];
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 chk("read back", v & MSK[i], rdata_o);
      @(posedge ref_clk_i);
    end
    wr(16'h4108, rnd());
    acc(1'b0, 16'h4108, 8'h00, q);
    chk("unmapped", 8'h00, q);
    $display("test registers done");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_IRSEL, 8'h00);
    wr(ADDR_FINE, 8'h00);
    // stopping the count clock clears divisor state left by random writes
    wr(ADDR_CLKSRC, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    for (int i = 0; i < 16; i++) begin
      f = 4'(i);
      v = rnd();
      // one source live at a time, each set up for 32 cycles a bit
      osc <= 4'h1 << f[1:0];
      wr(ADDR_BAUD, {7'h00, f[0]});
      wr(ADDR_CLKSRC, {4'h0, f[1:0], 2'b01});
      wr(ADDR_FORMAT, {3'h0, f, 1'b0});
      t0 = $time;
      wr(ADDR_TXHOLD, v);
      acc(1'b0, ADDR_STATUS, 8'h00, q);
      chk("busy", 8'h04, q & 8'h04);
      u_peer.recv(f, d, p);
      e = f[3] ? v : {1'b0, v[6:0]};
      chk("tx data", e, d);
      chk("tx parity", {7'h00, f[2] & (^e ^ f[1])}, {7'h00, p});
      wait_st(7, 1'b1);
      chk("frame bits", 8'(9 + f[3] + f[2] + f[0]), 8'((($time - t0) / 5 + 16) / 32));
      wr(ADDR_STATUS, 8'h80);
      acc(1'b0, ADDR_STATUS, 8'h00, q);
      chk("done cleared", 8'h01, q & 8'h85);
    end
    e = rnd();
    wr(ADDR_FORMAT, 8'h00);
    wr(ADDR_FINE, {5'h01, e[2:0]});
    t0 = $time;
    wr(ADDR_TXHOLD, rnd());
    wait_st(7, 1'b1);
    chk("fine frame", 8'h09, 8'((($time - t0) / 5 + (40 + e[2:0]) / 2) / (40 + e[2:0])));
    wr(ADDR_FINE, 8'h00);
    wr(ADDR_STATUS, 8'h80);
    $display("test transmit done");
    wr(ADDR_FORMAT, 8'h1C);
    wr(ADDR_CTRL, 8'h23);
    v = rnd();
    e = rnd();
    u_peer.send(v, 4'hE, 1'b0, 1'b0);
    acc(1'b0, ADDR_STATUS, 8'h00, q);
    chk("one byte", 8'h02, q & 8'h0A);
    chk("depth two quiet", 8'h00, {7'h00, irq_o});
    u_peer.send(e, 4'hE, 1'b0, 1'b0);
    acc(1'b0, ADDR_STATUS, 8'h00, q);
    chk("two bytes", 8'h0A, q & 8'h0A);
    chk("depth two", 8'h01, {7'h00, irq_o});
    acc(1'b0, ADDR_RXHOLD, 8'h00, q);
    chk("oldest", v, q);
    acc(1'b0, ADDR_RXHOLD, 8'h00, q);
    chk("newest", e, q);
    acc(1'b0, ADDR_STATUS, 8'h00, q);
    chk("drained", 8'h00, q & 8'h0A);
    wr(ADDR_CTRL, 8'h41);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_STATUS, 8'hF0);
      repeat (k == 0 ? 3 : 1) u_peer.send(rnd(), 4'hE, k == 1, k == 2);
      acc(1'b0, ADDR_STATUS, 8'h00, q);
      chk("error flag", 8'h10 << k, q & 8'h70);
      chk("error request", 8'h01, {7'h00, irq_o});
      repeat (2) acc(1'b0, ADDR_RXHOLD, 8'h00, q);
    end
    $display("test receive done");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_TXHOLD, rnd());
    u_peer.send(rnd(), 4'hE, 1'b0, 1'b0);
    acc(1'b0, ADDR_STATUS, 8'h00, q);
    chk("channel off", 8'h00, q & 8'h06);
    chk("line idle", 8'h01, {7'h00, txd_o});
    wr(ADDR_IRSEL, 8'h01);
    @(posedge ref_clk_i);
    #1 chk("infrared idle", 8'h00, {7'h00, txd_o});
    @(posedge ref_clk_i);
    wr(ADDR_CTRL, 8'h01);
    #1 chk("infrared pulse", 8'h01, {7'h00, txd_o});
    repeat (16) @(posedge ref_clk_i);
    #1 chk("infrared gap", 8'h00, {7'h00, txd_o});
    $display("test modes done");
    finish_test();
  end
endmodule
